// File: verif/sbc_ctrl_model.sv
// Purpose: controller model driving clock enable and command pins
// Assumes: one command per call, deselect on the edge after it
// Notes: idles on deselect with command lines high and bank and precharge lines low, never the terminator pattern
module sbc_ctrl_model
    import sbc_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // command pins towards the device
    output logic o_cke,
    output sbc_cmd_t o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // pins start idle with enable high, as the device expects around reset
    initial begin
        o_cke = 1'b1;
        o_cmd = {4'hF, 3'h0};
    end

    // no data pins here, so masking write data on read after write stays outside
    // one command, then a deselect gap; caller keeps refresh and mode gaps
    task automatic issue(input logic k, input logic [3:0] c, input logic [1:0] a,
                         input logic ap);
        @(posedge i_clk_sys);
        o_cke <= k;
        o_cmd <= {c, a, ap};
        @(posedge i_clk_sys);
        o_cmd <= {4'hF, 3'h0};
    endtask
endmodule

// File: verif/testbench.sv
// Purpose: self-checking bench for bank and clock-enable command tracking
// Assumes: shortened self-refresh exit time, banks 0 and 3 then a random bank choice on the last pass
// Notes: expected bank states kept by hand in eb
module testbench
    import sbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] TP = 8'h02;
    localparam logic [7:0] TA = 8'h02;
    localparam logic [7:0] TF = 8'h06;
    localparam logic [7:0] TM = 8'h02;
    localparam logic [7:0] TX = 8'h04;
    localparam logic [3:0] TB = 4'h2;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic cke, rej, tdis, mld, mext;
    sbc_cmd_t cmd;
    sbc_dev_state_t dev;
    sbc_bank_state_t [3:0] bk;
    sbc_bank_state_t [3:0] eb;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    logic [1:0] b, o;

    sbc_ctrl_model sbc_ctrl_model_inst (.i_clk_sys(i_clk_sys), .o_cke(cke), .o_cmd(cmd));
    sbc_bank_cmd_fsm #(.P_TRP(TP), .P_ACTIVATE_TO_ACCESS_TIME(TA), .P_TRC(TF), .P_MODE_LOAD_TIME(TM), .P_SELF_REFRESH_EXIT_TIME(TX),
        .P_BURST(TB)) sbc_bank_cmd_fsm_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_cke(cke), .i_cmd(cmd), .o_dev_state(dev), .o_bank_state(bk),
        .o_cmd_rejected(rej), .o_term_disable(tdis), .o_mode_load(mld), .o_mode_ext(mext));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // hang guard, far above the few hundred cycles the three passes need
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic go(input int k, input logic [3:0] c, input logic [1:0] a, input int ap);
        sbc_ctrl_model_inst.issue(1'(k), c, a, 1'(ap));
        #1;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic chk(input sbc_dev_state_t d, input logic r);
        cmp("device state", 12'(d), 12'(dev));
        cmp("bank states", eb, bk);
        cmp("rejected", 12'(r), 12'(rej));
    endtask
    task automatic all(input sbc_bank_state_t s);
        foreach (eb[i]) eb[i] = s;
    endtask
    // legal mode-load bank selects are 00 and 01; 1x is reserved
    function automatic logic mode_sel_legal(input int a);
        return (a < 2);
    endfunction
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: banks 0 and 3 first as corners for the bank-0 checks, then random
    initial begin
        void'($urandom(32'hC833));
        repeat (8) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        wt(4);
        for (int p = 0; p < 3; p++) begin
            b = (p == 0) ? 2'h0 : (p == 1) ? 2'h3 : 2'($urandom());
            o = b + 2'h1;
            all(SBC_BK_IDLE);
            eb[b] = SBC_BK_ACTIVATING;
            go(1, SBC_CMD_ACT, b, 0); chk(SBC_DEV_NORMAL, 0);
            eb[b] = SBC_BK_ACTIVE;
            wt(TA + 1); chk(SBC_DEV_NORMAL, 0);
            eb[o] = SBC_BK_ACTIVATING;
            go(1, SBC_CMD_ACT, o, 0); chk(SBC_DEV_NORMAL, 0);
            eb[o] = SBC_BK_ACTIVE;
            wt(TA + 1);
            eb[b] = SBC_BK_READ;
            go(1, SBC_CMD_READ, b, 0); chk(SBC_DEV_NORMAL, 0);
            go(1, SBC_CMD_PRE, b, 0); chk(SBC_DEV_NORMAL, 1);
            go(1, SBC_CMD_READ, b, 0); chk(SBC_DEV_NORMAL, 0);
            wt(TB);
            eb[b] = SBC_BK_WRITE;
            go(1, SBC_CMD_WRITE, b, 0); chk(SBC_DEV_NORMAL, 0);
            go(1, SBC_CMD_PRE, b, 0); chk(SBC_DEV_NORMAL, 1);
            // last pass writes with auto precharge so that state is reached too
            eb[o] = (p == 2) ? SBC_BK_WRITE_AP : SBC_BK_READ_AP;
            go(1, (p == 2) ? SBC_CMD_WRITE : SBC_CMD_READ, o, 1); chk(SBC_DEV_NORMAL, 0);
            eb[o] = SBC_BK_IDLE;
            wt(TB + TP + 1); chk(SBC_DEV_NORMAL, 0);
            eb[b] = SBC_BK_PRECHARGING;
            go(1, SBC_CMD_PRE, b, 0); chk(SBC_DEV_NORMAL, 0);
            eb[b] = SBC_BK_IDLE;
            wt(TP + 1); chk(SBC_DEV_NORMAL, 0);
            go(1, SBC_CMD_REF, b, 0); chk(SBC_DEV_REFRESH, 0);
            go(1, SBC_CMD_ACT, b, 0); chk(SBC_DEV_REFRESH, 1);
            wt(TF); chk(SBC_DEV_NORMAL, 0);
            for (int a = 0; a < 3; a++) begin
                go(1, SBC_CMD_MODE, 2'(a), 0);
                cmp("mode load", 12'(mode_sel_legal(a)), 12'(mld));
                cmp("rejected", 12'(!mode_sel_legal(a)), 12'(rej));
                if (a < 2) cmp("mode ext", 12'(a), 12'(mext));
                wt(TM + 1);
            end
            go(0, SBC_CMD_NOP, b, 0); chk(SBC_DEV_PD_PRE, 0);
            go(0, SBC_CMD_ACT, b, 0); chk(SBC_DEV_PD_PRE, 0);
            go(1, SBC_CMD_NOP, b, 0); chk(SBC_DEV_NORMAL, 0);
            eb[b] = SBC_BK_ACTIVE;
            go(1, SBC_CMD_ACT, b, 0);
            wt(TA + 1);
            go(0, SBC_CMD_NOP, b, 0); chk(SBC_DEV_PD_ACT, 0);
            go(1, SBC_CMD_NOP, b, 0); chk(SBC_DEV_NORMAL, 0);
            all(SBC_BK_PRECHARGING);
            go(1, SBC_CMD_PRE, b, 1); chk(SBC_DEV_PRE_ALL, 0);
            all(SBC_BK_IDLE);
            wt(TP + 1); chk(SBC_DEV_NORMAL, 0);
            go(0, SBC_CMD_REF, b, 0); chk(SBC_DEV_SELF_REF, 0);
            go(1, SBC_CMD_NOP, b, 0); chk(SBC_DEV_SR_EXIT, 0);
            wt(TX + 1); chk(SBC_DEV_NORMAL, 0);
            go(1, 4'hD, b, 0); cmp("terminator off", 12'h001, 12'(tdis));
            go(1, 4'h6, b, 0); chk(SBC_DEV_NORMAL, 1);
            $display("pass on bank %0d done", b);
        end
        finish_test();
    end
endmodule

// File: verilog/sbc_bank_cmd_fsm.sv
// Purpose: clock-enable and per-bank command state tracking of the memory device
// Assumes: command pins and clock enable launched on i_clk_sys by the controller
// Notes: commands that the state does not permit are ignored and flagged for one cycle unless clock enable is held low
module sbc_bank_cmd_fsm
    import sbc_pkg::*;
#(
    parameter logic [7:0] P_TRP = SBC_PRECHARGE_CYC,
    parameter logic [7:0] P_ACTIVATE_TO_ACCESS_TIME = SBC_ACT_ACCESS_CYC,
    parameter logic [7:0] P_TRC = SBC_REFRESH_CYC,
    parameter logic [7:0] P_MODE_LOAD_TIME = SBC_MODE_LOAD_CYC,
    parameter logic [7:0] P_SELF_REFRESH_EXIT_TIME = SBC_SR_EXIT_CYC,
    parameter logic [3:0] P_BURST = SBC_BURST_CYC
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // command pins from the controller
    input wire logic i_cke,
    input wire sbc_cmd_t i_cmd,
    // device and bank state
    output sbc_dev_state_t o_dev_state,
    output sbc_bank_state_t [SBC_NUM_BANKS-1:0] o_bank_state,
    // per-command indications
    output logic o_cmd_rejected,
    output logic o_term_disable,
    output logic o_mode_load,
    output logic o_mode_ext
);

    ////////////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta;
    logic rst_n;

    // async assert, release through two flops so all state leaves reset together
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command decode

    sbc_state_t r;
    sbc_state_t next_r;
    logic [3:0] cmd;
    logic is_nop;
    logic all_idle;
    logic pre_all_ok;
    logic reject_c;
    logic [1:0] ba;
    sbc_bank_t tb;

    // pin pattern and bank select
    always_comb begin
        cmd = {i_cmd.cs_n, i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
        ba = {i_cmd.bank_select_bit1, i_cmd.bank_select_bit0};
        is_nop = i_cmd.cs_n || (cmd == SBC_CMD_NOP);
        tb = r.banks[ba];
    end

    // all-idle and precharge-all checks across banks
    always_comb begin
        all_idle = 1'b1;
        pre_all_ok = 1'b1;
        for (int b = 0; b < SBC_NUM_BANKS; b++) begin
            if (r.banks[b].st != SBC_BK_IDLE) begin
                all_idle = 1'b0;
            end
            // each targeted bank must be open or idle with no burst running
            if (!((r.banks[b].st == SBC_BK_IDLE) || (r.banks[b].st == SBC_BK_ACTIVE) ||
                  (((r.banks[b].st == SBC_BK_READ) || (r.banks[b].st == SBC_BK_WRITE)) &&
                   (r.banks[b].burst == 4'h0)))) begin
                pre_all_ok = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_r = r;
        reject_c = 1'b0;
        next_r.cke_prev = i_cke;
        next_r.term_dis = 1'b0;
        next_r.mode_load = 1'b0;

        // bank timers run whatever else happens; a new command overrides below
        for (int b = 0; b < SBC_NUM_BANKS; b++) begin
            case (r.banks[b].st)
                SBC_BK_ACTIVATING, SBC_BK_PRECHARGING: begin
                    if (r.banks[b].cnt == 8'h00) begin
                        next_r.banks[b].st = (r.banks[b].st == SBC_BK_ACTIVATING) ?
                            SBC_BK_ACTIVE : SBC_BK_IDLE;
                    end else begin
                        next_r.banks[b].cnt = r.banks[b].cnt - 8'h01;
                    end
                end
                SBC_BK_READ, SBC_BK_WRITE: begin
                    if (r.banks[b].burst != 4'h0) begin
                        next_r.banks[b].burst = r.banks[b].burst - 4'h1;
                    end
                end
                SBC_BK_READ_AP, SBC_BK_WRITE_AP: begin
                    // access period first, then the automatic precharge period
                    if (r.banks[b].burst != 4'h0) begin
                        next_r.banks[b].burst = r.banks[b].burst - 4'h1;
                    end else if (r.banks[b].cnt == 8'h00) begin
                        next_r.banks[b].st = SBC_BK_IDLE;
                    end else begin
                        next_r.banks[b].cnt = r.banks[b].cnt - 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end

        // device-wide timed states
        if ((r.dev == SBC_DEV_REFRESH) || (r.dev == SBC_DEV_MODE) ||
            (r.dev == SBC_DEV_PRE_ALL) || (r.dev == SBC_DEV_SR_EXIT)) begin
            if (r.dcnt == 8'h00) begin
                next_r.dev = SBC_DEV_NORMAL;
            end else begin
                next_r.dcnt = r.dcnt - 8'h01;
            end
        end

        // termination disable is decoded only with chip select high
        if (i_cmd.cs_n && ({i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n} == SBC_TERM_DIS_RCW)) begin
            next_r.term_dis = 1'b1;
        end

        case ({r.cke_prev, i_cke})
            2'b00: begin
                // held low: power-down or self refresh stays, command ignored
                next_r.dev = r.dev;
            end
            2'b01: begin
                if (!is_nop) begin
                    reject_c = 1'b1;
                end else if ((r.dev == SBC_DEV_PD_PRE) || (r.dev == SBC_DEV_PD_ACT)) begin
                    next_r.dev = SBC_DEV_NORMAL;
                end else if (r.dev == SBC_DEV_SELF_REF) begin
                    next_r.dev = SBC_DEV_SR_EXIT;
                    next_r.dcnt = P_SELF_REFRESH_EXIT_TIME - 8'h01;
                end
            end
            2'b10: begin
                if ((r.dev == SBC_DEV_NORMAL) && is_nop) begin
                    next_r.dev = all_idle ? SBC_DEV_PD_PRE : SBC_DEV_PD_ACT;
                end else if ((r.dev == SBC_DEV_NORMAL) && (cmd == SBC_CMD_REF) && all_idle) begin
                    next_r.dev = SBC_DEV_SELF_REF;
                end else begin
                    reject_c = 1'b1;
                end
            end
            default: begin
                // both high: the bank tables apply once exits have timed out
                if (is_nop) begin
                    reject_c = 1'b0;
                end else if (r.dev != SBC_DEV_NORMAL) begin
                    reject_c = 1'b1;
                end else begin
                    // only the addressed bank's state matters for activate, read, write and single-bank precharge
                    case (cmd)
                        SBC_CMD_ACT: begin
                            if (tb.st == SBC_BK_IDLE) begin
                                next_r.banks[ba].st = SBC_BK_ACTIVATING;
                                next_r.banks[ba].cnt = P_ACTIVATE_TO_ACCESS_TIME - 8'h01;
                            end else begin
                                reject_c = 1'b1;
                            end
                        end
                        SBC_CMD_READ: begin
                            if ((tb.st == SBC_BK_ACTIVE) || (tb.st == SBC_BK_READ) ||
                                (tb.st == SBC_BK_WRITE)) begin
                                next_r.banks[ba].st = i_cmd.auto_precharge_select_bit ?
                                    SBC_BK_READ_AP : SBC_BK_READ;
                                next_r.banks[ba].burst = P_BURST;
                                next_r.banks[ba].cnt = P_TRP - 8'h01;
                            end else begin
                                reject_c = 1'b1;
                            end
                        end
                        SBC_CMD_WRITE: begin
                            if ((tb.st == SBC_BK_ACTIVE) || (tb.st == SBC_BK_WRITE) ||
                                ((tb.st == SBC_BK_READ) && (tb.burst == 4'h0))) begin
                                next_r.banks[ba].st = i_cmd.auto_precharge_select_bit ?
                                    SBC_BK_WRITE_AP : SBC_BK_WRITE;
                                next_r.banks[ba].burst = P_BURST;
                                next_r.banks[ba].cnt = P_TRP - 8'h01;
                            end else begin
                                reject_c = 1'b1;
                            end
                        end
                        SBC_CMD_PRE: begin
                            if (i_cmd.auto_precharge_select_bit) begin
                                // precharge all banks
                                if (pre_all_ok) begin
                                    for (int b = 0; b < SBC_NUM_BANKS; b++) begin
                                        next_r.banks[b].st = SBC_BK_PRECHARGING;
                                        next_r.banks[b].cnt = P_TRP - 8'h01;
                                    end
                                    next_r.dev = SBC_DEV_PRE_ALL;
                                    next_r.dcnt = P_TRP - 8'h01;
                                end else begin
                                    reject_c = 1'b1;
                                end
                            end else if ((tb.st == SBC_BK_ACTIVE) ||
                                         (((tb.st == SBC_BK_READ) || (tb.st == SBC_BK_WRITE)) &&
                                          (tb.burst == 4'h0))) begin
                                next_r.banks[ba].st = SBC_BK_PRECHARGING;
                                next_r.banks[ba].cnt = P_TRP - 8'h01;
                            end else begin
                                reject_c = 1'b1;
                            end
                        end
                        SBC_CMD_REF: begin
                            if (all_idle) begin
                                next_r.dev = SBC_DEV_REFRESH;
                                next_r.dcnt = P_TRC - 8'h01;
                            end else begin
                                reject_c = 1'b1;
                            end
                        end
                        default: begin
                            // mode load; bank select 1x and the unlisted pattern are refused
                            if (all_idle && (cmd == SBC_CMD_MODE) &&
                                !i_cmd.bank_select_bit1) begin
                                next_r.dev = SBC_DEV_MODE;
                                next_r.dcnt = P_MODE_LOAD_TIME - 8'h01;
                                next_r.mode_load = 1'b1;
                                next_r.mode_ext = i_cmd.bank_select_bit0;
                            end else begin
                                reject_c = 1'b1;
                            end
                        end
                    endcase
                end
            end
        endcase
        next_r.rejected = reject_c;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{dev: SBC_DEV_NORMAL, dcnt: 8'h00, cke_prev: SBC_CKE_PREV_RST,
                   banks: '0, rejected: 1'b0, term_dis: 1'b0, mode_load: 1'b0,
                   mode_ext: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // outputs are state flops, no logic after them
    always_comb begin
        o_dev_state = r.dev;
        for (int b = 0; b < SBC_NUM_BANKS; b++) begin
            o_bank_state[b] = r.banks[b].st;
        end
        o_cmd_rejected = r.rejected;
        o_term_disable = r.term_dis;
        o_mode_load = r.mode_load;
        o_mode_ext = r.mode_ext;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    localparam int ACTIVATE_TO_ACCESS_TIME_N = int'(P_ACTIVATE_TO_ACCESS_TIME);
    localparam int TRP_N = int'(P_TRP);
    localparam int TRC_N = int'(P_TRC);
    localparam int AP_N = int'(P_TRP) + int'(P_BURST);
    logic norm_cmd;
    assign norm_cmd = r.cke_prev && i_cke && !is_nop && (r.dev == SBC_DEV_NORMAL) && !reject_c;

    cke_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (!r.cke_prev && !i_cke && (r.dev == SBC_DEV_SELF_REF)) |=> (r.dev == SBC_DEV_SELF_REF))
        else $error("self refresh left while clock enable held low");
    cke_exit_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (!r.cke_prev && i_cke && is_nop &&
         ((r.dev == SBC_DEV_PD_PRE) || (r.dev == SBC_DEV_PD_ACT))) |=> (r.dev == SBC_DEV_NORMAL))
        else $error("power-down not exited on rising clock enable");
    pd_entry_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (r.cke_prev && !i_cke && is_nop && (r.dev == SBC_DEV_NORMAL)) |=>
        (r.dev == ($past(all_idle) ? SBC_DEV_PD_PRE : SBC_DEV_PD_ACT)))
        else $error("wrong power-down kind entered");
    sr_entry_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (r.cke_prev && !i_cke && (cmd == SBC_CMD_REF) && all_idle &&
         (r.dev == SBC_DEV_NORMAL)) |=> (r.dev == SBC_DEV_SELF_REF))
        else $error("self refresh not entered");
    act_time_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (norm_cmd && (cmd == SBC_CMD_ACT) && (ba == 2'h0)) |->
        ##1 (r.banks[0].st == SBC_BK_ACTIVATING) ##ACTIVATE_TO_ACCESS_TIME_N (r.banks[0].st == SBC_BK_ACTIVE))
        else $error("activate to active timing wrong");
    pre_time_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (norm_cmd && (cmd == SBC_CMD_PRE) && !i_cmd.auto_precharge_select_bit && (ba == 2'h0))
        |-> ##1 (r.banks[0].st == SBC_BK_PRECHARGING) ##TRP_N (r.banks[0].st == SBC_BK_IDLE))
        else $error("precharge to idle timing wrong");
    ref_time_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (norm_cmd && (cmd == SBC_CMD_REF)) |->
        ##1 (r.dev == SBC_DEV_REFRESH) ##TRC_N (r.dev == SBC_DEV_NORMAL))
        else $error("refresh cycle timing wrong");
    ap_idle_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (norm_cmd && (cmd == SBC_CMD_READ) && i_cmd.auto_precharge_select_bit && (ba == 2'h0))
        |-> ##1 (r.banks[0].st == SBC_BK_READ_AP) ##AP_N (r.banks[0].st == SBC_BK_IDLE))
        else $error("auto precharge read did not reach idle on time");
    rd_pre_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (r.cke_prev && i_cke && (r.dev == SBC_DEV_NORMAL) && (cmd == SBC_CMD_PRE) &&
         !i_cmd.auto_precharge_select_bit && (ba == 2'h0) &&
         (r.banks[0].st == SBC_BK_READ) && (r.banks[0].burst != 4'h0)) |=>
        (r.rejected && (r.banks[0].st == SBC_BK_READ)))
        else $error("precharge accepted during read burst");
    mode_sel_a: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n)
        (norm_cmd && (cmd == SBC_CMD_MODE)) |=>
        (r.mode_load && (r.mode_ext == $past(i_cmd.bank_select_bit0)) && (r.dev == SBC_DEV_MODE)))
        else $error("mode register select wrong");

endmodule

// File: verilog/sbc_pkg.sv
// Purpose: shared constants, encodings and carriers for the bank command state machine
// Assumes: 100 MHz device clock, commands launched by a controller on the same clock
// Notes: timing figures are in ns; cycle counts are derived and rounded up
package sbc_pkg;

    // clock and timing figures
    localparam int SBC_CLK_PERIOD_NS = 10;
    localparam int SBC_PRECHARGE_TIME_NS = 20;
    localparam int SBC_ACTIVATE_TO_ACCESS_TIME_NS = 20;
    localparam int SBC_REFRESH_CYCLE_TIME_NS = 60;
    localparam int SBC_MODE_LOAD_TIME_NS = 20;
    localparam int SBC_SELF_REFRESH_EXIT_TIME_NS = 200;
    localparam int SBC_BURST_NS = 20;

    // least times, rounded up to whole cycles
    localparam logic [7:0] SBC_PRECHARGE_CYC =
        8'((SBC_PRECHARGE_TIME_NS + SBC_CLK_PERIOD_NS - 1) / SBC_CLK_PERIOD_NS);
    localparam logic [7:0] SBC_ACT_ACCESS_CYC =
        8'((SBC_ACTIVATE_TO_ACCESS_TIME_NS + SBC_CLK_PERIOD_NS - 1) / SBC_CLK_PERIOD_NS);
    localparam logic [7:0] SBC_REFRESH_CYC =
        8'((SBC_REFRESH_CYCLE_TIME_NS + SBC_CLK_PERIOD_NS - 1) / SBC_CLK_PERIOD_NS);
    localparam logic [7:0] SBC_MODE_LOAD_CYC =
        8'((SBC_MODE_LOAD_TIME_NS + SBC_CLK_PERIOD_NS - 1) / SBC_CLK_PERIOD_NS);
    localparam logic [7:0] SBC_SR_EXIT_CYC =
        8'((SBC_SELF_REFRESH_EXIT_TIME_NS + SBC_CLK_PERIOD_NS - 1) / SBC_CLK_PERIOD_NS);
    localparam logic [3:0] SBC_BURST_CYC =
        4'((SBC_BURST_NS + SBC_CLK_PERIOD_NS - 1) / SBC_CLK_PERIOD_NS);

    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] SBC_CMD_NOP = 4'h7;
    localparam logic [3:0] SBC_CMD_ACT = 4'h3;
    localparam logic [3:0] SBC_CMD_READ = 4'h5;
    localparam logic [3:0] SBC_CMD_WRITE = 4'h4;
    localparam logic [3:0] SBC_CMD_PRE = 4'h2;
    localparam logic [3:0] SBC_CMD_REF = 4'h1;
    localparam logic [3:0] SBC_CMD_MODE = 4'h0;
    localparam logic [2:0] SBC_TERM_DIS_RCW = 3'h5;

    // reset values
    localparam logic SBC_CKE_PREV_RST = 1'b1;
    localparam int SBC_NUM_BANKS = 4;

    typedef enum logic [2:0] {
        SBC_DEV_NORMAL = 3'h0,
        SBC_DEV_PD_PRE = 3'h1,
        SBC_DEV_PD_ACT = 3'h3,
        SBC_DEV_SELF_REF = 3'h2,
        SBC_DEV_SR_EXIT = 3'h6,
        SBC_DEV_REFRESH = 3'h7,
        SBC_DEV_MODE = 3'h5,
        SBC_DEV_PRE_ALL = 3'h4
    } sbc_dev_state_t;

    typedef enum logic [2:0] {
        SBC_BK_IDLE = 3'h0,
        SBC_BK_ACTIVATING = 3'h1,
        SBC_BK_ACTIVE = 3'h3,
        SBC_BK_READ = 3'h2,
        SBC_BK_WRITE = 3'h6,
        SBC_BK_READ_AP = 3'h7,
        SBC_BK_WRITE_AP = 3'h5,
        SBC_BK_PRECHARGING = 3'h4
    } sbc_bank_state_t;

    // command pins as registered at one edge
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bank_select_bit1;
        logic bank_select_bit0;
        logic auto_precharge_select_bit;
    } sbc_cmd_t;

    typedef struct packed {
        sbc_bank_state_t st;
        logic [7:0] cnt;
        logic [3:0] burst;
    } sbc_bank_t;

    typedef struct packed {
        sbc_dev_state_t dev;
        logic [7:0] dcnt;
        logic cke_prev;
        sbc_bank_t [SBC_NUM_BANKS-1:0] banks;
        logic rejected;
        logic term_dis;
        logic mode_load;
        logic mode_ext;
    } sbc_state_t;

endpackage
